//--- src/arg_pkg.sv
// arg_pkg: sizes, register map, types of the alert reporting gate
// assumes one 25 MHz hclk and an AHB-Lite register port
package arg_pkg;
  // ==========================================================
  // sizes and timing
  localparam int NUM_ALERTS  = 19;
  localparam int NUM_CATS    = 3;
  localparam int PRI_W       = 4;
  localparam int IDX_W       = 7;
  localparam int ADDR_LSB    = 2;
  localparam int TMR_W       = 24;
  localparam int CLK_FREQ_HZ = 25_000_000;
  localparam int ACK_TIMEOUT_US  = 1000;
  localparam int ACK_TIMEOUT_CYC =
    ACK_TIMEOUT_US * (CLK_FREQ_HZ / 1_000_000);
  // ==========================================================
  // alerts allowed in any transducer mode
  localparam int AL_PROC_IMPAIRED = 2;
  localparam int AL_OUT_TIMEOUT   = 3;
  localparam int AL_SET_DEFAULTS  = 4;
  localparam int AL_OUT_PRES_SENS = 6;
  localparam int AL_SUP_PRES_SENS = 7;
  localparam int AL_TEMP_SENS     = 8;
  localparam logic [NUM_ALERTS-1:0] ANY_MODE_MASK = NUM_ALERTS'(
    (1 << AL_PROC_IMPAIRED) | (1 << AL_OUT_TIMEOUT) |
    (1 << AL_SET_DEFAULTS)  | (1 << AL_OUT_PRES_SENS) |
    (1 << AL_SUP_PRES_SENS) | (1 << AL_TEMP_SENS));
  // ==========================================================
  // register indices, byte address is index times four
  localparam logic [IDX_W-1:0] IDX_NONE              = 7'h00;
  localparam logic [IDX_W-1:0] IDX_FAIL_SUPPRESS     = 7'd65;
  localparam logic [IDX_W-1:0] IDX_UPKEEP_SUPPRESS   = 7'd66;
  localparam logic [IDX_W-1:0] IDX_ADVISORY_SUPPRESS = 7'd67;
  localparam logic [IDX_W-1:0] IDX_FAIL_PRIORITY     = 7'd68;
  localparam logic [IDX_W-1:0] IDX_UPKEEP_PRIORITY   = 7'd69;
  localparam logic [IDX_W-1:0] IDX_ADVISORY_PRIORITY = 7'd70;
  localparam logic [IDX_W-1:0] IDX_COND_ENABLE       = 7'd71;
  localparam logic [IDX_W-1:0] IDX_FAIL_CAT_EN       = 7'd72;
  localparam logic [IDX_W-1:0] IDX_CONTROL           = 7'd75;
  localparam logic [IDX_W-1:0] IDX_ACK_TIMEOUT       = 7'd76;
  localparam logic [IDX_W-1:0] IDX_SIM_VALUE         = 7'd77;
  localparam logic [IDX_W-1:0] IDX_ACTIVE            = 7'd78;
  localparam logic [IDX_W-1:0] IDX_BUS_REPORTED      = 7'd79;
  localparam logic [IDX_W-1:0] IDX_SIM_REPORTED      = 7'd80;
  localparam logic [IDX_W-1:0] IDX_OUTSTANDING       = 7'd81;
  localparam logic [IDX_W-1:0] IDX_SETS_READBACK     = 7'd97;
  // ==========================================================
  // control bits and reset values
  localparam int CTL_W          = 4;
  localparam int CTL_REPORT_SEL = 0;
  localparam int CTL_SD_LATCH   = 1;
  localparam int CTL_SD_CLEAR   = 2;
  localparam int CTL_SIM_EN     = 3;
  localparam logic [CTL_W-1:0] CTL_CLEAR_MASK  = 4'h4;
  localparam logic [CTL_W-1:0] RST_CONTROL     = 4'h1;
  localparam logic [PRI_W-1:0] PRI_SIM         = 4'h1;
  localparam logic [PRI_W-1:0] RST_PRIORITY    = 4'h2;
  localparam logic [NUM_ALERTS-1:0] RST_COND_EN  = 19'h7FFFF;
  localparam logic [NUM_ALERTS-1:0] RST_FAIL_CAT = 19'h7FFFF;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MODE_AUTO           = 2'b00,
    MODE_MANUAL         = 2'b01,
    MODE_OUT_OF_SERVICE = 2'b10,
    MODE_LOCAL_OVERRIDE = 2'b11
  } arg_mode_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ  = 2'b01,
    ST_WAIT = 2'b10
  } arg_state_type;
  typedef struct packed {
    logic                  valid;
    logic [1:0]            category;
    logic [PRI_W-1:0]      prio;
    logic [NUM_ALERTS-1:0] alerts;
  } arg_notify_type;
  typedef struct packed {
    logic       valid;
    logic [1:0] category;
  } arg_ack_type;
endpackage

//--- src/arg_top.sv
// arg_top: alert qualification, category gating, notify and retry
// assumes an AHB-Lite master on hclk and a bus stack that sends the
// notify word and returns acknowledgments by category
`timescale 1ns/1ps
`default_nettype none
module arg_top #(
  parameter int ACK_TIMEOUT_CYC = arg_pkg::ACK_TIMEOUT_CYC,
  parameter int TMR_W           = arg_pkg::TMR_W
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic [31:0]               hrdata,
  output logic                      hresp,
  input  wire logic [arg_pkg::NUM_ALERTS-1:0] alert_cond,
  input  wire logic                 shutdown_active,
  input  wire arg_pkg::arg_mode_type   trans_mode,
  input  wire arg_pkg::arg_ack_type    ack,
  output arg_pkg::arg_notify_type      notify,
  output logic                      readback_alert
);
  import arg_pkg::*;

  localparam int NA = NUM_ALERTS;
  localparam int NC = NUM_CATS;

  if (TMR_W < 2 || TMR_W > 32 || ACK_TIMEOUT_CYC < 1 ||
      ACK_TIMEOUT_CYC >= (64'd1 << TMR_W)) begin : g_chk
    $error("arg_top: timer width cannot hold the ack timeout");
  end
  // ==========================================================
  // bus slave state
  logic                  wr_pend_r;
  logic                  rd_pend_r;
  logic [IDX_W-1:0]      wr_idx_r;
  logic [IDX_W-1:0]      rd_idx_r;
  logic                  hreadyout_r;
  logic [31:0]           hrdata_r;
  logic [31:0]           rd_mux;
  // software registers
  logic [NA-1:0]         supp_r [NC];
  logic [NA-1:0]         cat_en_r [NC];
  logic [PRI_W-1:0]      pri_r [NC];
  logic [NA-1:0]         cond_en_r;
  logic [CTL_W-1:0]      ctl_r;
  logic [TMR_W-1:0]      ack_tmo_r;
  logic [NA-1:0]         sim_val_r;
  logic                  sets_rb_r;
  logic                  sd_latch_r;
  // notify engine
  arg_state_type         st_r [NC];
  logic [TMR_W-1:0]      tmr_r [NC];
  logic [NA-1:0]         pend_r [NC];
  logic [NA-1:0]         snap_r [NC];
  logic [NA-1:0]         prev_r [NC];
  logic [NA-1:0]         bus_rep [NC];
  logic [NA-1:0]         sim_rep [NC];
  arg_notify_type        notify_r;
  logic                  readback_r;
  logic                  gnt_vld;
  logic [1:0]            gnt_cat;
  logic [PRI_W-1:0]      gnt_pri;

  function automatic logic wr_hit(input logic [IDX_W-1:0] idx);
    return wr_pend_r && (wr_idx_r == idx);
  endfunction
  // ==========================================================
  // AHB-Lite slave: writes zero wait, reads one wait state
  wire addr_ok = hsel & htrans[1] & hready;
  wire mapped  = (haddr[31:ADDR_LSB+IDX_W] == '0) &&
                 (haddr[ADDR_LSB-1:0] == '0);
  wire [IDX_W-1:0] a_idx =
    mapped ? haddr[ADDR_LSB +: IDX_W] : IDX_NONE;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r   <= 1'b0;
      rd_pend_r   <= 1'b0;
      wr_idx_r    <= IDX_NONE;
      rd_idx_r    <= IDX_NONE;
      hreadyout_r <= 1'b1;
      hrdata_r    <= '0;
    end else begin
      wr_pend_r   <= addr_ok & hwrite;
      rd_pend_r   <= addr_ok & ~hwrite;
      hreadyout_r <= ~(addr_ok & ~hwrite);
      if (addr_ok) begin
        wr_idx_r <= a_idx;
        rd_idx_r <= a_idx;
      end
      if (rd_pend_r) begin
        hrdata_r <= rd_mux;
      end
    end
  end
  assign hreadyout = hreadyout_r;
  assign hrdata    = hrdata_r;
  assign hresp     = 1'b0 & hsize[0];
  // ==========================================================
  // qualification
  wire report_sel = ctl_r[CTL_REPORT_SEL];
  wire sim_en     = ctl_r[CTL_SIM_EN];
  wire sd_clear   = wr_hit(IDX_CONTROL) & hwdata[CTL_SD_CLEAR];
  wire sd_present = shutdown_active | sd_latch_r;
  wire mode_auto  = (trans_mode == MODE_AUTO);
  wire [NA-1:0] cond_src  = sim_en ? sim_val_r : alert_cond;
  wire [NA-1:0] cond_eval = cond_src & cond_en_r;
  wire [NA-1:0] mode_ok = ANY_MODE_MASK |
    {NA{mode_auto | sd_present | sim_en}};
  wire [NA-1:0] cat_any = cat_en_r[0] | cat_en_r[1] | cat_en_r[2];
  // four tests for an active alert
  wire [NA-1:0] active = cond_eval & cat_any & mode_ok;

  for (genvar c = 0; c < NC; c++) begin : g_gate
    wire [NA-1:0] cand = active & cat_en_r[c] & ~supp_r[c] &
                         {NA{report_sel}};
    assign bus_rep[c] = cand & {NA{pri_r[c] > PRI_SIM}};
    assign sim_rep[c] = cand & {NA{pri_r[c] == PRI_SIM}};
  end
  // ==========================================================
  // register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int c = 0; c < NC; c++) begin
        supp_r[c]   <= '0;
        cat_en_r[c] <= (c == 0) ? RST_FAIL_CAT : '0;
        pri_r[c]    <= RST_PRIORITY;
      end
      cond_en_r <= RST_COND_EN;
      ctl_r     <= RST_CONTROL;
      ack_tmo_r <= TMR_W'(ACK_TIMEOUT_CYC);
      sim_val_r <= '0;
      sets_rb_r <= 1'b0;
    end else begin
      for (int c = 0; c < NC; c++) begin
        if (wr_hit(IDX_W'(IDX_FAIL_SUPPRESS + c))) begin
          supp_r[c] <= hwdata[NA-1:0];
        end
        if (wr_hit(IDX_W'(IDX_FAIL_CAT_EN + c))) begin
          cat_en_r[c] <= hwdata[NA-1:0];
        end
        if (wr_hit(IDX_W'(IDX_FAIL_PRIORITY + c))) begin
          pri_r[c] <= hwdata[PRI_W-1:0];
        end
      end
      if (wr_hit(IDX_COND_ENABLE)) begin
        cond_en_r <= hwdata[NA-1:0];
      end
      if (wr_hit(IDX_CONTROL)) begin
        ctl_r <= hwdata[CTL_W-1:0] & ~CTL_CLEAR_MASK;
      end
      if (wr_hit(IDX_ACK_TIMEOUT)) begin
        ack_tmo_r <= hwdata[TMR_W-1:0];
      end
      if (wr_hit(IDX_SIM_VALUE)) begin
        sim_val_r <= hwdata[NA-1:0];
      end
      if (wr_hit(IDX_SETS_READBACK)) begin
        sets_rb_r <= hwdata[0];
      end
    end
  end
  // shutdown latch, a new shutdown beats the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sd_latch_r <= 1'b0;
    end else if (shutdown_active & ctl_r[CTL_SD_LATCH]) begin
      sd_latch_r <= 1'b1;
    end else if (sd_clear) begin
      sd_latch_r <= 1'b0;
    end
  end
  // ==========================================================
  // read mux
  wire [CTL_W-1:0] ctl_view = ctl_r |
    (sd_latch_r ? CTL_CLEAR_MASK : '0);

  always_comb begin
    rd_mux = '0;
    case (rd_idx_r)
      IDX_FAIL_SUPPRESS:     rd_mux = 32'(supp_r[0]);
      IDX_UPKEEP_SUPPRESS:   rd_mux = 32'(supp_r[1]);
      IDX_ADVISORY_SUPPRESS: rd_mux = 32'(supp_r[2]);
      IDX_FAIL_PRIORITY:     rd_mux = 32'(pri_r[0]);
      IDX_UPKEEP_PRIORITY:   rd_mux = 32'(pri_r[1]);
      IDX_ADVISORY_PRIORITY: rd_mux = 32'(pri_r[2]);
      IDX_COND_ENABLE:       rd_mux = 32'(cond_en_r);
      IDX_FAIL_CAT_EN:       rd_mux = 32'(cat_en_r[0]);
      IDX_FAIL_CAT_EN + 7'd1: rd_mux = 32'(cat_en_r[1]);
      IDX_FAIL_CAT_EN + 7'd2: rd_mux = 32'(cat_en_r[2]);
      IDX_CONTROL:           rd_mux = 32'(ctl_view);
      IDX_ACK_TIMEOUT:       rd_mux = 32'(ack_tmo_r);
      IDX_SIM_VALUE:         rd_mux = 32'(sim_val_r);
      IDX_ACTIVE:            rd_mux = 32'(active);
      IDX_BUS_REPORTED:
        rd_mux = 32'(bus_rep[0] | bus_rep[1] | bus_rep[2]);
      IDX_SIM_REPORTED:
        rd_mux = 32'(sim_rep[0] | sim_rep[1] | sim_rep[2]);
      IDX_OUTSTANDING:
        rd_mux = 32'({st_r[2] != ST_IDLE, st_r[1] != ST_IDLE,
                      st_r[0] != ST_IDLE});
      IDX_SETS_READBACK:     rd_mux = 32'(sets_rb_r);
      default:               rd_mux = '0;
    endcase
  end
  // ==========================================================
  // arbiter: one notification per cycle
  // highest priority wins, ties go to the failed side
  always_comb begin
    gnt_vld = 1'b0;
    gnt_cat = '0;
    gnt_pri = '0;
    for (int c = 0; c < NC; c++) begin
      if (st_r[c] == ST_REQ && pri_r[c] > PRI_SIM &&
          (!gnt_vld || pri_r[c] > gnt_pri)) begin
        gnt_vld = 1'b1;
        gnt_cat = 2'(c);
        gnt_pri = pri_r[c];
      end
    end
  end
  // ==========================================================
  // per-category notify and retry engine
  for (genvar c = 0; c < NC; c++) begin : g_cat
    wire [NA-1:0] rise = bus_rep[c] & ~prev_r[c];
    wire granted  = gnt_vld && (gnt_cat == 2'(c));
    wire ack_hit  = ack.valid && (ack.category == 2'(c));

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        st_r[c]   <= ST_IDLE;
        tmr_r[c]  <= '0;
        pend_r[c] <= '0;
        snap_r[c] <= '0;
        prev_r[c] <= '0;
      end else begin
        prev_r[c] <= bus_rep[c];
        pend_r[c] <= pend_r[c] | rise;
        unique case (st_r[c])
          ST_IDLE: begin
            if (|(pend_r[c] | rise)) begin
              snap_r[c] <= pend_r[c] | rise;
              pend_r[c] <= '0;
              st_r[c]   <= ST_REQ;
            end
          end
          ST_REQ: begin
            // priority at or below one drops it
            if (pri_r[c] <= PRI_SIM) begin
              st_r[c] <= ST_IDLE;
            end else if (granted) begin
              tmr_r[c] <= ack_tmo_r;
              st_r[c]  <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            if (ack_hit) begin
              st_r[c] <= ST_IDLE;
            end else if (tmr_r[c] == '0) begin
              st_r[c] <= ST_REQ;
            end else begin
              tmr_r[c] <= tmr_r[c] - TMR_W'(1);
            end
          end
          default: st_r[c] <= ST_IDLE;
        endcase
      end
    end
  end
  // ==========================================================
  // outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      notify_r   <= '0;
      readback_r <= 1'b0;
    end else begin
      notify_r.valid    <= gnt_vld;
      notify_r.category <= gnt_cat;
      notify_r.prio     <= gnt_pri;
      notify_r.alerts   <= snap_r[gnt_cat];
      readback_r <= sets_rb_r & (|active);
    end
  end
  assign notify         = notify_r;
  assign readback_alert = readback_r;
  // ==========================================================
  // assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_notify_follows_grant;
    gnt_vld |=> notify_r.valid && notify_r.category == $past(gnt_cat);
  endproperty
  a_notify_follows_grant: assert property (p_notify_follows_grant)
    else $error("grant not followed by notify");
  property p_bus_priority;
    notify_r.valid |-> notify_r.prio > PRI_SIM && report_sel;
  endproperty
  a_bus_priority: assert property (p_bus_priority)
    else $error("notify sent with low priority or no select");
  property p_mode_gate;
    !mode_auto && !sd_present && !sim_en |->
      (active & ~ANY_MODE_MASK) == '0;
  endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("auto-only alert active outside auto");
  property p_disabled_idle;
    (active & ~cond_en_r) == '0;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle)
    else $error("disabled condition became active");
  property p_readback;
    sets_rb_r && (|active) ##1 sets_rb_r |-> readback_r;
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback flag missing while alert active");
  property p_latch_hold;
    sd_latch_r && !sd_clear |=> sd_latch_r;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("shutdown latch dropped without clear");
  for (genvar c = 0; c < NC; c++) begin : g_chk_cat
    property p_timer_load;
      gnt_vld && gnt_cat == 2'(c) |=>
        st_r[c] == ST_WAIT && tmr_r[c] == $past(ack_tmo_r);
    endproperty
    a_timer_load: assert property (p_timer_load)
      else $error("timer not reloaded on send");
    property p_retry;
      st_r[c] == ST_WAIT && tmr_r[c] == '0 &&
        !(ack.valid && ack.category == 2'(c)) |=>
        st_r[c] == ST_REQ ##1 st_r[c] == ST_REQ || st_r[c] == ST_WAIT;
    endproperty
    a_retry: assert property (p_retry)
      else $error("no retransmission after timeout");
    property p_keep_waiting;
      st_r[c] == ST_WAIT && tmr_r[c] != '0 &&
        !(ack.valid && ack.category == 2'(c)) |=>
        st_r[c] == ST_WAIT && $stable(snap_r[c]);
    endproperty
    a_keep_waiting: assert property (p_keep_waiting)
      else $error("wait abandoned without acknowledgment");
    property p_precedence;
      gnt_vld && st_r[c] == ST_REQ && pri_r[c] > PRI_SIM |->
        pri_r[c] <= gnt_pri;
    endproperty
    a_precedence: assert property (p_precedence)
      else $error("lower priority category granted first");
    property p_low_pri_drop;
      st_r[c] == ST_REQ && pri_r[c] <= PRI_SIM |=> st_r[c] == ST_IDLE;
    endproperty
    a_low_pri_drop: assert property (p_low_pri_drop)
      else $error("priority 0 or 1 request not dropped");
  end
endmodule
`default_nettype wire

//--- tb/arg_host_model.sv
// arg_host_model: fieldbus host that answers notify words with acks
// assumes the notify and ack structs of arg_pkg on the gate's hclk
`timescale 1ns/1ps
`default_nettype none
module arg_host_model (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire arg_pkg::arg_notify_type notify,
  input  wire logic                ack_on,
  input  wire logic [3:0]          ack_dly,
  output arg_pkg::arg_ack_type     ack
);
  import arg_pkg::*;
  logic [3:0] wait_r;
  logic [1:0] cat_r;
  // ==========================================================
  // acknowledge engine
  // ack notifications while ack_on is set; a new one restarts a pending delay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack    <= '0;
      wait_r <= 4'h0;
      cat_r  <= 2'h0;
    end else begin
      ack <= '0;
      if (notify.valid && ack_on && ack_dly == 4'h0) begin
        ack <= '{valid: 1'b1, category: notify.category};
      end else if (notify.valid && ack_on) begin
        wait_r <= ack_dly;
        cat_r  <= notify.category;
      end else if (wait_r == 4'h1) begin
        ack    <= '{valid: 1'b1, category: cat_r};
        wait_r <= 4'h0;
      end else if (wait_r != 4'h0) begin
        wait_r <= wait_r - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/test_alert_report_gating.sv
// test_alert_report_gating: register and notify checks of the gate
// assumes arg_top with a short ack timer and the host model beside it
`timescale 1ns/1ps
`default_nettype none
module test_alert_report_gating;
  import arg_pkg::*;
  logic hclk, hresetn, hsel, hwrite, shutdown_active, ack_on;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  ack_dly;
  logic [18:0] alert_cond;
  wire logic   hreadyout, hresp, readback_alert;
  arg_mode_type   trans_mode;
  arg_ack_type    ack;
  arg_notify_type notify, last_nfy;
  int num_errors = 0, checks_done = 0, nfy_cnt = 0;
  arg_top #(.ACK_TIMEOUT_CYC(8)) i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .alert_cond(alert_cond), .shutdown_active(shutdown_active),
    .trans_mode(trans_mode), .ack(ack), .notify(notify),
    .readback_alert(readback_alert));
  arg_host_model i_host (.hclk(hclk), .hresetn(hresetn), .notify(notify),
    .ack_on(ack_on), .ack_dly(ack_dly), .ack(ack));
  // ==========================================================
  // clock, monitor, verdict
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (notify.valid === 1'b1) begin
      nfy_cnt++;
      last_nfy = notify;
    end
  end
  task automatic conclude();
    if (num_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ==========================================================
  // AHB-Lite single word transfer
  task automatic ahb(input logic wr, input logic [6:0] idx,
                     input logic [31:0] wd, output logic [31:0] rdv);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {23'h0, idx, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic wr(input logic [6:0] idx, input logic [31:0] wd);
    ahb(1'b1, idx, wd, rd);
  endtask
  task automatic rchk(input logic [6:0] idx, input logic [31:0] exp);
    ahb(1'b0, idx, 32'h0, rd);
    chk(rd, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    conclude();
  end
  // ==========================================================
  // test sequence
  initial begin
    hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'b00;
    haddr = 32'h0; hwdata = 32'h0; hsize = 3'b010; ack_on = 1'b0;
    ack_dly = 4'h2; alert_cond = 19'h0; shutdown_active = 1'b0;
    trans_mode = MODE_AUTO;
    cyc(20);
    hresetn <= 1'b1;
    for (int i = 68; i <= 70; i++) rchk(7'(i), 32'h2);
    rchk(7'd97, 32'h0);
    rchk(7'h10, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    wr(7'd76, 32'h8);
    // notify, retry after clear, then ack stops retry
    alert_cond <= 19'h1;
    cyc(4);
    alert_cond <= 19'h0;
    cyc(40);
    chk(32'(nfy_cnt >= 3), 32'h1);
    chk({13'h0, last_nfy.alerts}, 32'h1);
    rchk(7'd81, 32'h1);
    ack_on <= 1'b1;
    cyc(30);
    rchk(7'd81, 32'h0);
    // mode requirements per alert
    alert_cond <= 19'h7FFFF;
    for (int m = 0; m < 4; m++) begin
      trans_mode <= arg_mode_type'(m);
      cyc(3);
      rchk(7'd78, (m == 0) ? 32'h7FFFF : 32'h1DC);
    end
    trans_mode <= MODE_OUT_OF_SERVICE;
    shutdown_active <= 1'b1;
    cyc(3);
    rchk(7'd78, 32'h7FFFF);
    // latched shutdown keeps reporting out of service until cleared
    wr(7'd75, 32'h3);
    cyc(1);
    shutdown_active <= 1'b0;
    cyc(2);
    rchk(7'd78, 32'h7FFFF);
    rchk(7'd75, 32'h7);
    wr(7'd75, 32'h5);
    rchk(7'd78, 32'h1DC);
    rchk(7'd75, 32'h1);
    trans_mode <= MODE_AUTO;
    wr(7'd71, 32'h0);
    cyc(2);
    rchk(7'd78, 32'h0);
    wr(7'd71, 32'h7FFFF);
    wr(7'd75, 32'h9);
    wr(7'd77, 32'h2);
    trans_mode <= MODE_MANUAL;
    cyc(3);
    rchk(7'd78, 32'h2);
    wr(7'd71, 32'h7FFFD);
    rchk(7'd78, 32'h0);
    wr(7'd71, 32'h7FFFF);
    wr(7'd75, 32'h1);
    trans_mode <= MODE_AUTO;
    // priority, suppress and feature select on the fail category
    alert_cond <= 19'h4;
    for (int p = 0; p < 4; p++) begin
      wr(7'd68, (p == 3) ? 32'hF : 32'(p));
      cyc(2);
      rchk(7'd79, (p >= 2) ? 32'h4 : 32'h0);
      rchk(7'd80, (p == 1) ? 32'h4 : 32'h0);
    end
    wr(7'd65, 32'h4);
    cyc(2);
    rchk(7'd79, 32'h0);
    wr(7'd65, 32'h0);
    wr(7'd75, 32'h0);
    cyc(2);
    rchk(7'd79, 32'h0);
    wr(7'd75, 32'h1);
    // readback status follows active alerts
    wr(7'd97, 32'h1);
    cyc(2);
    chk({31'h0, readback_alert}, 32'h1);
    alert_cond <= 19'h0;
    cyc(3);
    chk({31'h0, readback_alert}, 32'h0);
    // reassign to upkeep category with its own priority
    wr(7'd72, 32'h0);
    wr(7'd73, 32'h4);
    wr(7'd69, 32'h5);
    alert_cond <= 19'h4;
    cyc(6);
    chk({30'h0, last_nfy.category}, 32'h1);
    chk({28'h0, last_nfy.prio}, 32'h5);
    conclude();
  end
endmodule
`default_nettype wire
